// ===== bench/serial_tx_model.sv
// Behavioural remote transmitter that drives the receiver's serial line.
`timescale 1ns/1ps
module serial_tx_model (
    // Clock
    input  wire logic clock,
    // Serial line toward the receiver
    output logic      line
);
    // The transmitter always drives the line, so idle is a driven high level.
    initial line = 1'b1;

    // Send one frame; stop_lvl low makes a deliberately broken stop bit.
    task automatic send(input logic [8:0] data, input int nbits, input logic stop_lvl,
                        input int bit_clks);
        int i;
        line <= 1'b0;
        repeat (bit_clks) @(posedge clock);
        for (i = 0; i < nbits; i++) begin
            line <= data[i];
            repeat (bit_clks) @(posedge clock);
        end
        line <= stop_lvl;
        repeat (bit_clks) @(posedge clock);
        line <= 1'b1;
        repeat (2 * bit_clks) @(posedge clock);
    endtask

    // A low pulse far shorter than half a bit, as noise would make.
    task automatic glitch(input int clks);
        line <= 1'b0;
        repeat (clks) @(posedge clock);
        line <= 1'b1;
        repeat (48) @(posedge clock);
    endtask
endmodule

// ===== bench/tb.sv
// Self-checking testbench for the asynchronous serial receiver.
`timescale 1ns/1ps
module tb;
    import async_rx_pkg::*;

    logic        clock;
    logic        rstn;
    logic        rx_line;
    logic [4:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [4:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        irq;
    int          n_fail;
    int          cmp_count;
    logic [1:0]  bq[$];
    logic [65:0] rq[$];

    async_serial_receiver dut_u (
        .clock(clock), .rstn(rstn), .rx_input_pin(rx_line),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq)
    );

    serial_tx_model tx_u (.clock(clock), .line(rx_line));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic test_end(input string name);
        $display("test %s done at %0t", name, $time);
    endtask

    // Address and data are offered together; each is dropped once its own ready was seen.
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_p;
        logic w_p;
        aw_p = 1'b1;
        w_p  = 1'b1;
        bq.push_back(r);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hF;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge clock);
            if (aw_p && s_axi_awready) begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_p && s_axi_wready) begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge clock);
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask

    task automatic axi_rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m,
                          input logic [1:0] r);
        rq.push_back({m, e, r});
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge clock);
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask

    // Responses are judged against the oldest note, in the order they were issued.
    always @(posedge clock) begin
        logic [65:0] e;
        if (s_axi_bvalid && s_axi_bready) begin
            check(32'(s_axi_bresp), 32'(bq.pop_front()));
        end
        if (s_axi_rvalid && s_axi_rready) begin
            e = rq.pop_front();
            check(s_axi_rdata & e[65:34], e[33:2] & e[65:34]);
            check(32'(s_axi_rresp), 32'(e[1:0]));
        end
    end

    initial begin
        repeat (40000) @(posedge clock);
        n_fail++;
        complete_run();
    end

    initial begin
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] c3;
        logic [8:0] d9;
        int         k;
        n_fail = 0;
        cmp_count = 0;
        rstn = 1'b0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        void'($urandom(96320));
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        axi_rd(CTRL_OFS, 32'h0000_0000, 32'h0000_000F, RESP_OKAY);
        axi_rd(BAUD_OFS, 32'(BAUD_RST), 32'h0000_FFFF, RESP_OKAY);
        axi_rd(STATUS_OFS, 32'h0000_0000, 32'h0000_000F, RESP_OKAY);
        axi_rd(IRQ_EN_OFS, 32'h0000_0000, 32'h0000_0007, RESP_OKAY);
        axi_rd(5'h1C, 32'h0000_0000, 32'h0000_0000, RESP_SLVERR);
        axi_wr(STATUS_OFS, 32'h0000_000F, RESP_SLVERR);
        axi_wr(DATA_OFS, 32'h0000_00FF, RESP_SLVERR);
        axi_wr(IRQ_EN_OFS, 32'h0000_0007, RESP_OKAY);
        axi_wr(CTRL_OFS, 32'h0000_0003, RESP_OKAY);
        test_end("reset");
        // Two bit rates show the shifter stepping once per sixteen ticks.
        for (k = 0; k < 2; k++) begin
            axi_wr(BAUD_OFS, 32'(k), RESP_OKAY);
            // The divider only picks up a new divisor when its running period ends.
            repeat (int'(BAUD_RST) + 2) @(posedge clock);
            c1 = 8'($urandom);
            tx_u.send({1'b0, c1}, 8, 1'b1, 16 * (k + 1));
            axi_rd(STATUS_OFS, 32'h0000_0003, 32'h0000_000F, RESP_OKAY);
            axi_rd(IRQ_ST_OFS, 32'h0000_0001, 32'h0000_0007, RESP_OKAY);
            check(32'(irq), 32'h0000_0001);
            axi_wr(CTRL_OFS, 32'h0000_0002, RESP_OKAY);
            axi_rd(STATUS_OFS, 32'h0000_0002, 32'h0000_000F, RESP_OKAY);
            axi_wr(CTRL_OFS, 32'h0000_0003, RESP_OKAY);
            axi_rd(DATA_OFS, 32'(c1), 32'h0000_03FF, RESP_OKAY);
            axi_rd(STATUS_OFS, 32'h0000_0000, 32'h0000_000F, RESP_OKAY);
        end
        axi_wr(BAUD_OFS, 32'h0000_0000, RESP_OKAY);
        axi_wr(IRQ_EN_OFS, 32'h0000_0000, RESP_OKAY);
        @(posedge clock);
        check(32'(irq), 32'h0000_0000);
        axi_wr(IRQ_CLR_OFS, 32'h0000_0007, RESP_OKAY);
        axi_wr(IRQ_EN_OFS, 32'h0000_0007, RESP_OKAY);
        axi_rd(IRQ_ST_OFS, 32'h0000_0000, 32'h0000_0007, RESP_OKAY);
        @(posedge clock);
        check(32'(irq), 32'h0000_0000);
        test_end("basic");
        c1 = 8'($urandom);
        c2 = 8'($urandom);
        c3 = 8'($urandom);
        tx_u.send({1'b0, c1}, 8, 1'b1, 16);
        tx_u.send({1'b0, c2}, 8, 1'b1, 16);
        axi_rd(STATUS_OFS, 32'h0000_0005, 32'h0000_000F, RESP_OKAY);
        // The third frame starts while both entries are still unread.
        fork
            tx_u.send({1'b0, c3}, 8, 1'b1, 16);
            begin
                repeat (40) @(posedge clock);
                axi_rd(DATA_OFS, 32'(c1), 32'h0000_03FF, RESP_OKAY);
            end
        join
        axi_rd(DATA_OFS, 32'(c2), 32'h0000_03FF, RESP_OKAY);
        axi_rd(DATA_OFS, 32'(c3), 32'h0000_03FF, RESP_OKAY);
        axi_rd(DATA_OFS, 32'h0000_0000, 32'h0000_03FF, RESP_OKAY);
        axi_rd(IRQ_ST_OFS, 32'h0000_0001, 32'h0000_0007, RESP_OKAY);
        test_end("fifo");
        tx_u.send({1'b0, c1}, 8, 1'b0, 16);
        axi_rd(STATUS_OFS, 32'h0000_000B, 32'h0000_000F, RESP_OKAY);
        axi_rd(IRQ_ST_OFS, 32'h0000_0003, 32'h0000_0007, RESP_OKAY);
        axi_rd(DATA_OFS, 32'h0000_0200 | 32'(c1), 32'h0000_03FF, RESP_OKAY);
        tx_u.send({1'b0, c2}, 8, 1'b1, 16);
        axi_rd(DATA_OFS, 32'(c2), 32'h0000_03FF, RESP_OKAY);
        test_end("framing");
        axi_wr(IRQ_CLR_OFS, 32'h0000_0007, RESP_OKAY);
        tx_u.glitch(4);
        axi_rd(STATUS_OFS, 32'h0000_0000, 32'h0000_000F, RESP_OKAY);
        axi_rd(IRQ_ST_OFS, 32'h0000_0000, 32'h0000_0007, RESP_OKAY);
        axi_wr(CTRL_OFS, 32'h0000_000B, RESP_OKAY);
        d9 = 9'($urandom);
        tx_u.send(d9, 9, 1'b1, 16);
        axi_rd(DATA_OFS, 32'(d9), 32'h0000_03FF, RESP_OKAY);
        test_end("glitch and nine bit");
        // One control setting per condition that must keep the receiver idle: sync set, port enable off, continuous enable off.
        for (k = 0; k < 3; k++) begin
            axi_wr(CTRL_OFS, (k == 0) ? 32'h0000_0007 : 32'(k), RESP_OKAY);
            tx_u.send({1'b0, 8'($urandom)}, 8, 1'b1, 16);
            axi_rd(STATUS_OFS, 32'h0000_0000, 32'h0000_0006, RESP_OKAY);
        end
        axi_wr(CTRL_OFS, 32'h0000_0003, RESP_OKAY);
        // All-ones data keeps the line high after the abort, so no false start appears.
        fork
            tx_u.send(9'h0FF, 8, 1'b1, 16);
            begin
                repeat (48) @(posedge clock);
                axi_wr(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
                axi_wr(CTRL_OFS, 32'h0000_0003, RESP_OKAY);
            end
        join
        axi_rd(STATUS_OFS, 32'h0000_0000, 32'h0000_0006, RESP_OKAY);
        c1 = 8'($urandom);
        tx_u.send({1'b0, c1}, 8, 1'b1, 16);
        axi_rd(DATA_OFS, 32'(c1), 32'h0000_03FF, RESP_OKAY);
        test_end("enables and abort");
        // A third character with both entries unread is dropped as an overrun.
        axi_wr(IRQ_CLR_OFS, 32'h0000_0007, RESP_OKAY);
        for (k = 0; k < 3; k++) begin
            tx_u.send({1'b0, 8'(k + 1)}, 8, 1'b1, 16);
        end
        axi_rd(IRQ_ST_OFS, 32'h0000_0005, 32'h0000_0007, RESP_OKAY);
        axi_rd(DATA_OFS, 32'h0000_0001, 32'h0000_03FF, RESP_OKAY);
        axi_rd(DATA_OFS, 32'h0000_0002, 32'h0000_03FF, RESP_OKAY);
        test_end("overrun");
        complete_run();
    end
endmodule

// ===== design/async_rx_pkg.sv
// Constants, register map and types shared by the asynchronous serial receiver.
package async_rx_pkg;

    localparam int unsigned CLK_HZ     = 50_000_000;
    localparam int unsigned OVERSAMPLE = 16;
    localparam int unsigned FIFO_DEPTH = 2;
    localparam int unsigned DIV_W      = 16;

    // Tick index within a bit at which a bit is decided.
    // Samples 7, 8 and 9 are voted, so the vote is centred on the half-bit point.
    localparam logic [3:0] HALF_BIT    = 4'h8;
    localparam logic [3:0] DECIDE_TICK = 4'h9;
    localparam logic [3:0] EDGE_TICK   = 4'h0;

    // Register byte offsets.
    localparam logic [4:0] CTRL_OFS    = 5'h00;
    localparam logic [4:0] STATUS_OFS  = 5'h04;
    localparam logic [4:0] DATA_OFS    = 5'h08;
    localparam logic [4:0] BAUD_OFS    = 5'h0C;
    localparam logic [4:0] IRQ_ST_OFS  = 5'h10;
    localparam logic [4:0] IRQ_CLR_OFS = 5'h14;
    localparam logic [4:0] IRQ_EN_OFS  = 5'h18;

    // Control register fields.
    localparam int unsigned CTRL_RX_CONTINUOUS_ENABLE_BIT = 0;
    localparam int unsigned CTRL_SERIAL_PORT_ENABLE_BIT = 1;
    localparam int unsigned CTRL_SYNC_BIT = 2;
    localparam int unsigned CTRL_NINE_BIT = 3;
    localparam logic [3:0]  CTRL_RST      = 4'h0;

    // Status register fields.
    localparam int unsigned STAT_PEND_BIT = 0;
    localparam int unsigned STAT_CNT_LSB  = 1;
    localparam int unsigned STAT_FERR_BIT = 3;

    // Data register: character in bits 8:0, its framing error in bit 9.
    localparam int unsigned DATA_FERR_BIT = 9;

    // Baud divisor: one oversample tick every (divisor + 1) clocks.
    localparam logic [15:0] BAUD_RST = 16'h0144;

    // Interrupt status, clear and enable share this layout.
    localparam int unsigned IRQ_RX_BIT   = 0;
    localparam int unsigned IRQ_FERR_BIT = 1;
    localparam int unsigned IRQ_OVR_BIT  = 2;
    localparam logic [2:0]  IRQ_RST      = 3'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

// ===== design/async_serial_receiver.sv
// Asynchronous serial receiver with two-entry FIFO behind an AXI4-Lite slave.
//
// What this block does
// - The line is sampled at sixteen ticks per bit while the shift register moves once per bit.
// - A finished eight- or nine-bit character moves whole into a FIFO of two entries.
// - With two unread characters held, reception of a third may still begin.
// - Software sees characters only through the receive data register, never the shifter.
// - Reception runs only with continuous enable 1, sync mode 0 and port enable 1.
// - A character starts on a falling edge of the line; the start bit is low.
// - Half a bit after the edge the line is checked to be still low.
// - A start bit found high at its middle is dropped silently and the search resumes.
// - Each data bit is taken one bit time apart by majority vote into the shifter.
// - The stop bit is sampled one bit after the last data bit; low marks a framing error.
// - After the stop bit the character enters the FIFO unless it is full, and the pending flag is raised.
// - Reading the data register returns the oldest character and removes it.
// - The pending flag is read-only and shows an unread character while enabled.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module async_serial_receiver
    import async_rx_pkg::*;
#(
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Serial line
    input  wire logic        rx_input_pin,
    // AXI4-Lite write address and data
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Interrupt
    output logic             irq
);

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    // Control and configuration state.
    logic [3:0]  ctrl_ff;
    logic [15:0] baud_ff;
    logic [2:0]  irq_st_ff;
    logic [2:0]  irq_en_ff;

    logic rx_continuous_enable;
    logic serial_port_enable;
    logic run;
    assign rx_continuous_enable = ctrl_ff[CTRL_RX_CONTINUOUS_ENABLE_BIT];
    assign serial_port_enable   = ctrl_ff[CTRL_SERIAL_PORT_ENABLE_BIT];
    assign run = rx_continuous_enable & serial_port_enable & ~ctrl_ff[CTRL_SYNC_BIT];

    logic tick;
    baud_tick_gen #(.W(DIV_W)) u_baud (
        .clock   (clock),
        .rstn    (rstn),
        .divisor (baud_ff),
        .tick    (tick)
    );

    // Line synchroniser and three-sample history.
    logic       rx_meta_ff;
    logic       rx_sync_ff;
    logic [1:0] hist_ff;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
        end else begin
            rx_meta_ff <= rx_input_pin;
            rx_sync_ff <= rx_meta_ff;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hist_ff <= 2'h3;
        end else if (tick) begin
            hist_ff <= {hist_ff[0], rx_sync_ff};
        end
    end

    logic fall;
    logic maj;
    assign fall = tick & hist_ff[0] & ~rx_sync_ff;
    assign maj  = maj3(hist_ff[1], hist_ff[0], rx_sync_ff);

    // Receive state machine.
    rx_state_t  state_ff;
    logic [3:0] tcnt_ff;
    logic [3:0] bit_ff;
    logic [8:0] receive_shift_reg;
    logic       decide;
    logic       push;
    logic       pop;
    logic [3:0] nbits;
    assign decide = tick & (tcnt_ff == DECIDE_TICK);
    assign push   = (state_ff == RX_STOP) & decide & run;
    assign nbits  = ctrl_ff[CTRL_NINE_BIT] ? 4'h9 : 4'h8;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_ff <= RX_IDLE;
            tcnt_ff  <= EDGE_TICK;
            bit_ff   <= 4'h0;
        end else if (!run) begin
            state_ff <= RX_IDLE;
            tcnt_ff  <= EDGE_TICK;
        end else begin
            if (tick) begin
                tcnt_ff <= tcnt_ff + 4'h1;
            end
            case (state_ff)
                RX_IDLE: begin
                    // A full FIFO does not hold off a new start.
                    if (fall) begin
                        state_ff <= RX_START;
                        tcnt_ff  <= EDGE_TICK + 4'h1;
                    end
                end
                RX_START: begin
                    if (decide) begin
                        state_ff <= maj ? RX_IDLE : RX_DATA;
                        bit_ff   <= 4'h0;
                    end
                end
                RX_DATA: begin
                    if (decide) begin
                        bit_ff <= bit_ff + 4'h1;
                        if (bit_ff == nbits - 4'h1) begin
                            state_ff <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (decide) begin
                        state_ff <= RX_IDLE;
                    end
                end
                default: state_ff <= RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            receive_shift_reg <= 9'h000;
        end else if (state_ff == RX_DATA && decide) begin
            receive_shift_reg <= {maj, receive_shift_reg[8:1]};
        end
    end

    // Two-entry FIFO: character plus its framing error bit.
    logic [9:0]    fifo_mem [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [CW-1:0] fifo_cnt_ff;
    logic          fifo_full;
    logic [8:0]    rx_char;
    assign fifo_full = (fifo_cnt_ff == CW'(DEPTH));
    assign rx_char   = ctrl_ff[CTRL_NINE_BIT] ? receive_shift_reg
                                              : {1'b0, receive_shift_reg[8:1]};

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // An overflowing character is discarded so unread ones are never corrupted.
    always_ff @(posedge clock) begin
        if (push && !fifo_full) begin
            fifo_mem[wr_ptr_ff] <= {~maj, rx_char};
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_ff   <= '0;
            rd_ptr_ff   <= '0;
            fifo_cnt_ff <= '0;
        end else begin
            if (push && !fifo_full) begin
                wr_ptr_ff <= ptr_inc(wr_ptr_ff);
            end
            if (pop) begin
                rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            end
            fifo_cnt_ff <= fifo_cnt_ff + CW'(push && !fifo_full) - CW'(pop);
        end
    end

    logic rx_pending_flag;
    assign rx_pending_flag = rx_continuous_enable & (fifo_cnt_ff != '0);

    // AXI4-Lite write path.
    logic        aw_have_ff;
    logic        w_have_ff;
    logic [4:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic        wr_go;
    logic        wr_hit;
    assign wr_go  = aw_have_ff & w_have_ff & ~s_axi_bvalid;
    assign wr_hit = (awaddr_ff == CTRL_OFS) | (awaddr_ff == BAUD_OFS)
                  | (awaddr_ff == IRQ_CLR_OFS) | (awaddr_ff == IRQ_EN_OFS);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            awaddr_ff  <= 5'h00;
            wdata_ff   <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_ff    <= 1'b1;
                s_axi_awready <= 1'b0;
                awaddr_ff     <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_have_ff    <= 1'b0;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_ff    <= 1'b1;
                s_axi_wready <= 1'b0;
                wdata_ff     <= s_axi_wdata;
            end else if (wr_go) begin
                w_have_ff    <= 1'b0;
                s_axi_wready <= 1'b1;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Byte lane 0 carries every writable field except the upper baud byte, which lane 1 carries.
    logic [3:0] strb_ff;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            strb_ff <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            strb_ff <= s_axi_wstrb;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff   <= CTRL_RST;
            baud_ff   <= BAUD_RST;
            irq_en_ff <= IRQ_RST;
        end else if (wr_go) begin
            if (strb_ff[0] && awaddr_ff == CTRL_OFS) begin
                ctrl_ff <= wdata_ff[3:0];
            end
            if (strb_ff[0] && awaddr_ff == BAUD_OFS) begin
                baud_ff[7:0] <= wdata_ff[7:0];
            end
            if (strb_ff[1] && awaddr_ff == BAUD_OFS) begin
                baud_ff[15:8] <= wdata_ff[15:8];
            end
            if (strb_ff[0] && awaddr_ff == IRQ_EN_OFS) begin
                irq_en_ff <= wdata_ff[2:0];
            end
        end
    end

    // Sticky events; a new event wins over a clear in the same cycle.
    logic [2:0] irq_ev;
    logic [2:0] irq_clr;
    assign irq_ev  = {push & fifo_full, push & ~maj, push};
    assign irq_clr = (wr_go && strb_ff[0] && awaddr_ff == IRQ_CLR_OFS) ? wdata_ff[2:0] : 3'h0;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_st_ff <= IRQ_RST;
            irq       <= 1'b0;
        end else begin
            irq_st_ff <= (irq_st_ff & ~irq_clr) | irq_ev;
            irq       <= |(irq_st_ff & irq_en_ff);
        end
    end

    // AXI4-Lite read path.
    logic [31:0] rd_word;
    logic        rd_hit;
    logic [9:0]  fifo_top;
    assign fifo_top = fifo_mem[rd_ptr_ff];
    assign pop = s_axi_arvalid & s_axi_arready & (s_axi_araddr == DATA_OFS)
               & (fifo_cnt_ff != '0);

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            CTRL_OFS:   rd_word[3:0] = ctrl_ff;
            STATUS_OFS: begin
                rd_word[STAT_PEND_BIT] = rx_pending_flag;
                rd_word[STAT_CNT_LSB +: 2] = 2'(fifo_cnt_ff);
                rd_word[STAT_FERR_BIT] = (fifo_cnt_ff != '0) & fifo_top[DATA_FERR_BIT];
            end
            DATA_OFS:   rd_word[9:0] = (fifo_cnt_ff != '0) ? fifo_top : 10'h000;
            BAUD_OFS:   rd_word[15:0] = baud_ff;
            IRQ_ST_OFS: rd_word[2:0] = irq_st_ff;
            IRQ_CLR_OFS: rd_word = 32'h0000_0000;
            IRQ_EN_OFS: rd_word[2:0] = irq_en_ff;
            default:    rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // Checks.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_start_decide;
        run && state_ff == RX_START && decide;
    endsequence
    sequence s_stop_decide;
        run && state_ff == RX_STOP && decide;
    endsequence

    property p_false_start;
        s_start_decide ##0 maj |=> state_ff == RX_IDLE
            && fifo_cnt_ff == $past(fifo_cnt_ff) - CW'($past(pop));
    endproperty
    a_false_start: assert property (p_false_start) else $error("false start not dropped");

    property p_start_ok;
        s_start_decide ##0 !maj |=> state_ff == RX_DATA && bit_ff == 4'h0;
    endproperty
    a_start_ok: assert property (p_start_ok) else $error("valid start not taken");

    property p_edge;
        run && state_ff == RX_IDLE && fall |=> state_ff == RX_START;
    endproperty
    a_edge: assert property (p_edge) else $error("falling edge missed");

    property p_push;
        s_stop_decide ##0 !fifo_full && !pop
            |=> fifo_cnt_ff == $past(fifo_cnt_ff) + 1'b1 && irq_st_ff[IRQ_RX_BIT];
    endproperty
    a_push: assert property (p_push) else $error("character not queued after stop");

    property p_frame;
        s_stop_decide ##0 !maj |=> irq_st_ff[IRQ_FERR_BIT];
    endproperty
    a_frame: assert property (p_frame) else $error("framing error not flagged");

    property p_pop;
        pop && !push |=> fifo_cnt_ff == $past(fifo_cnt_ff) - 1'b1
            ##0 s_axi_rvalid && s_axi_rdata[9:0] == $past(fifo_top);
    endproperty
    a_pop: assert property (p_pop) else $error("data read did not pop oldest");

    property p_abort;
        !run |=> state_ff == RX_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("disabled receiver not idle");

    property p_bit_spacing;
        run && state_ff == RX_DATA && decide |=> !decide [*8];
    endproperty
    a_bit_spacing: assert property (p_bit_spacing) else $error("bits decided too close");

    property p_irq;
        |(irq_st_ff & irq_en_ff) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule

// ===== design/baud_tick_gen.sv
// Divider that turns the system clock into the sixteen-times-baud tick.
`timescale 1ns/1ps
module baud_tick_gen
    import async_rx_pkg::*;
#(
    parameter int unsigned W = DIV_W
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rstn,
    // Divisor and tick
    input  wire logic [W-1:0] divisor,
    output logic              tick
);

    logic [W-1:0] cnt_ff;

    // Reloading at zero means a new divisor takes effect after the running period.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= '0;
            tick   <= 1'b0;
        end else if (cnt_ff == '0) begin
            cnt_ff <= divisor;
            tick   <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff - 1'b1;
            tick   <= 1'b0;
        end
    end

endmodule
